// *** core/ccr_defs.vh ***
// constants for the core clock, reset and interrupt input block
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// apb register byte offsets
`define CCR_A_STATUS 12'h000
`define CCR_A_ENABLE 12'h004
`define CCR_A_CLEAR 12'h008
`define CCR_A_CTRL 12'h00C
`define CCR_A_IDENT 12'h010
`define CCR_A_RATIO 12'h014

// status, enable and clear bit positions
`define CCR_EV_FPU 0
`define CCR_EV_MASKABLE_IRQ_IN 1
`define CCR_EV_TEST 2
`define CCR_EV_FCLR 3
`define CCR_EV_W 4

// control register bits and reset value
`define CCR_CTRL_IF 0
`define CCR_CTRL_TEST 1
`define CCR_CTRL_RST 2'h0

// ratio register fields
`define CCR_RF_MUL_HI 3
`define CCR_RF_RNG_LO 4
`define CCR_RF_RNG_HI 5
`define CCR_RF_TST 6
`define CCR_RF_SEL_LO 8
`define CCR_RF_SEL_HI 10

// identification ranges
`define CCR_RNG_EARLY 2'h0
`define CCR_RNG_MID 2'h1
`define CCR_RNG_LATE 2'h2

// multiplier values
`define CCR_X4 4'h4
`define CCR_X5 4'h5
`define CCR_X6 4'h6
`define CCR_X7 4'h7
`define CCR_X8 4'h8
`define CCR_X9 4'h9
`define CCR_X10 4'hA

// fpu error clear i/o addresses
`define CCR_IO_FCLR0 16'h00F0
`define CCR_IO_FCLR1 16'h00F1

// cache invalidation walk
`define CCR_LINE_W 8
`define CCR_LINE_LAST 8'hFF
`define CCR_LINE_ZERO 8'h00

// misc
`define CCR_ZERO32 32'h0000_0000
`define CCR_SEL_RST 3'h0
`define CCR_MUL_RST 4'h4

`endif

// *** core/ccr_top.v ***
// core clock ratio, reset sequencing and interrupt input logic
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ccr_defs.vh"

// Function
// - clock is bus-synchronous common timing reference
// - pll multiplies system clock, up to ten
// - three select inputs choose core ratio
// - select msb only honoured on latest revision
// - ident register value picks ratio table
// - earliest table: 4 test,6,7,5
// - middle table: 4 test,6,7,8
// - latest table: 4t,10,9,5,4,6,7,8
// - reset aborts all, restarts from known state
// - reset invalidates every cache line
// - reset async, synchronized to clock edge
// - no warm reset input, done in software
// - level irq input enters service routine
// - irq ignored while interrupt flag clear
// - fpu error asserts error interrupt output
// - out to f0h or f1h clears it
module ccr_top #(
  // identification value and range starts, values arbitrary
  parameter [7:0] IDENT_VALUE = 8'h24,
  parameter [7:0] IDENT_MID_MIN = 8'h10,
  parameter [7:0] IDENT_LATE_MIN = 8'h20
) (
  // clock and reset
  input wire MCLK,
  input wire RST_N,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // board straps
  input wire [2:0] CORE_RATIO_SELECT,
  // pll control
  output wire [3:0] PLL_MULT,
  output wire PLL_TEST_ONLY,
  // core reset and cache invalidation
  output wire CORE_RST_N,
  output wire CACHE_INV_WE,
  output wire [7:0] CACHE_INV_IDX,
  // maskable interrupt
  input wire MASKABLE_IRQ_IN,
  input wire IRQ_DONE,
  output wire IRQ_TAKE,
  // fpu error interrupt
  input wire FPU_ERROR,
  input wire IO_WR,
  input wire [15:0] IO_ADDR,
  output wire FPU_ERROR_IRQ_OUT,
  // block interrupt
  output wire INT_OUT
);

  localparam [1:0] ST_RESET = 2'h0;
  localparam [1:0] ST_INVAL = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // reset synchronizer
  reg rst_m_r;
  reg rst_s_r;
  // strap and irq synchronizers
  reg [2:0] sel_m_r;
  reg [2:0] sel_s_r;
  reg irq_m_r;
  reg irq_s_r;
  // sequencer
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] line_r;
  reg [7:0] line_nxt;
  reg inv_we_r;
  reg core_rst_n_r;
  // ratio
  reg [3:0] mult_r;
  reg tst_r;
  reg [2:0] sel_hold_r;
  reg [3:0] dec_mult;
  reg dec_tst;
  reg [1:0] rng;
  // interrupts
  reg busy_r;
  reg take_r;
  reg fpu_irq_r;
  reg [3:0] stat_r;
  reg [3:0] stat_nxt;
  reg [3:0] en_r;
  reg [1:0] ctrl_r;
  reg int_r;
  // apb
  reg [31:0] rdata_r;
  reg ready_r;
  reg err_r;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire acc;
  wire take;
  wire fclr;
  wire [3:0] ev;
  wire [3:0] clr;

  // identification range lookup
  always @* begin
    if (IDENT_VALUE >= IDENT_LATE_MIN) begin
      rng = `CCR_RNG_LATE;
    end else if (IDENT_VALUE >= IDENT_MID_MIN) begin
      rng = `CCR_RNG_MID;
    end else begin
      rng = `CCR_RNG_EARLY;
    end
  end

  // ratio table decode
  always @* begin
    dec_mult = `CCR_X4;
    dec_tst = 1'b0;
    if (rng == `CCR_RNG_LATE) begin
      case (sel_s_r)
        3'h0: begin
          dec_mult = `CCR_X4;
          dec_tst = 1'b1;
        end
        3'h1: dec_mult = `CCR_X10;
        3'h2: dec_mult = `CCR_X9;
        3'h3: dec_mult = `CCR_X5;
        3'h4: dec_mult = `CCR_X4;
        3'h5: dec_mult = `CCR_X6;
        3'h6: dec_mult = `CCR_X7;
        default: dec_mult = `CCR_X8;
      endcase
    end else begin
      case (sel_s_r[1:0])
        2'h0: begin
          dec_mult = `CCR_X4;
          dec_tst = 1'b1;
        end
        2'h1: dec_mult = `CCR_X6;
        2'h2: dec_mult = `CCR_X7;
        default: begin
          if (rng == `CCR_RNG_MID) begin
            dec_mult = `CCR_X8;
          end else begin
            dec_mult = `CCR_X5;
          end
        end
      endcase
    end
  end

  // reset synchronizer, release on a defined edge
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // pin synchronizers
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_m_r <= `CCR_SEL_RST;
      sel_s_r <= `CCR_SEL_RST;
      irq_m_r <= 1'b0;
      irq_s_r <= 1'b0;
    end else begin
      sel_m_r <= CORE_RATIO_SELECT;
      sel_s_r <= sel_m_r;
      irq_m_r <= MASKABLE_IRQ_IN;
      irq_s_r <= irq_m_r;
    end
  end

  // reset sequencer: hold core in reset and walk cache lines
  always @* begin
    state_nxt = state_r;
    line_nxt = line_r;
    case (state_r)
      ST_RESET: begin
        line_nxt = `CCR_LINE_ZERO;
        if (rst_s_r) begin
          state_nxt = ST_INVAL;
        end
      end
      ST_INVAL: begin
        line_nxt = line_r + 8'h01;
        if (line_r == `CCR_LINE_LAST) begin
          state_nxt = ST_RUN;
          line_nxt = `CCR_LINE_ZERO;
        end
      end
      ST_RUN: begin
        line_nxt = `CCR_LINE_ZERO;
      end
      default: begin
        state_nxt = ST_RESET;
        line_nxt = `CCR_LINE_ZERO;
      end
    endcase
  end

  // only the cold reset pin exists; warm reset is software
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_RESET;
      line_r <= `CCR_LINE_ZERO;
      inv_we_r <= 1'b0;
      core_rst_n_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      line_r <= line_nxt;
      inv_we_r <= (state_nxt == ST_INVAL);
      core_rst_n_r <= (state_nxt == ST_RUN);
    end
  end

  // ratio captured while core reset held, frozen in run
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mult_r <= `CCR_MUL_RST;
      tst_r <= 1'b0;
      sel_hold_r <= `CCR_SEL_RST;
    end else if (state_r == ST_INVAL) begin
      mult_r <= dec_mult;
      tst_r <= dec_tst;
      sel_hold_r <= sel_s_r;
    end
  end

  // maskable interrupt acceptance
  assign take = irq_s_r & ctrl_r[`CCR_CTRL_IF] & ~busy_r & (state_r == ST_RUN);

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_r <= 1'b0;
      take_r <= 1'b0;
    end else begin
      take_r <= take;
      if (take) begin
        busy_r <= 1'b1;
      end else if (IRQ_DONE | (state_r != ST_RUN)) begin
        busy_r <= 1'b0;
      end
    end
  end

  // fpu error interrupt, set wins over clear
  assign fclr = IO_WR & ((IO_ADDR == `CCR_IO_FCLR0) | (IO_ADDR == `CCR_IO_FCLR1));

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      fpu_irq_r <= 1'b0;
    end else if (state_r != ST_RUN) begin
      fpu_irq_r <= 1'b0;
    end else if (FPU_ERROR) begin
      fpu_irq_r <= 1'b1;
    end else if (fclr) begin
      fpu_irq_r <= 1'b0;
    end
  end

  // apb handshake: one wait state, write at the ready edge
  assign acc = PSEL & PENABLE & ready_r;

  always @* begin
    rd_mux = `CCR_ZERO32;
    rd_hit = 1'b1;
    case (PADDR)
      `CCR_A_STATUS: rd_mux[`CCR_EV_W-1:0] = stat_r;
      `CCR_A_ENABLE: rd_mux[`CCR_EV_W-1:0] = en_r;
      `CCR_A_CLEAR: rd_mux = `CCR_ZERO32;
      `CCR_A_CTRL: rd_mux[`CCR_CTRL_TEST:0] = ctrl_r;
      `CCR_A_IDENT: rd_mux[7:0] = IDENT_VALUE;
      `CCR_A_RATIO: begin
        rd_mux[`CCR_RF_MUL_HI:0] = mult_r;
        rd_mux[`CCR_RF_RNG_HI:`CCR_RF_RNG_LO] = rng;
        rd_mux[`CCR_RF_TST] = tst_r;
        rd_mux[`CCR_RF_SEL_HI:`CCR_RF_SEL_LO] = sel_hold_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ready_r <= 1'b0;
      rdata_r <= `CCR_ZERO32;
      err_r <= 1'b0;
    end else begin
      ready_r <= PSEL & PENABLE & ~ready_r;
      if (PSEL & PENABLE & ~ready_r) begin
        rdata_r <= PWRITE ? `CCR_ZERO32 : rd_mux;
        err_r <= ~rd_hit;
      end else begin
        err_r <= 1'b0;
      end
    end
  end

  // event bits: fpu error, irq taken, test-only ratio, fpu clear
  assign ev[`CCR_EV_FPU] = FPU_ERROR & (state_r == ST_RUN);
  assign ev[`CCR_EV_MASKABLE_IRQ_IN] = take;
  assign ev[`CCR_EV_TEST] = (state_r == ST_INVAL) & (state_nxt == ST_RUN) & tst_r;
  assign ev[`CCR_EV_FCLR] = fclr & (state_r == ST_RUN);
  assign clr = (acc & PWRITE & (PADDR == `CCR_A_CLEAR)) ? PWDATA[`CCR_EV_W-1:0] : 4'h0;

  always @* begin
    stat_nxt = (stat_r & ~clr) | ev;
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_r <= 4'h0;
      en_r <= 4'h0;
      ctrl_r <= `CCR_CTRL_RST;
      int_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      int_r <= |(stat_r & en_r);
      if (acc & PWRITE & (PADDR == `CCR_A_ENABLE)) begin
        en_r <= PWDATA[`CCR_EV_W-1:0];
      end
      if (acc & PWRITE & (PADDR == `CCR_A_CTRL)) begin
        ctrl_r <= PWDATA[`CCR_CTRL_TEST:0];
      end
    end
  end

  // outputs, all straight from flip-flops; MCLK is the bus reference
  assign PRDATA = rdata_r;
  assign PREADY = ready_r;
  assign PSLVERR = err_r;
  assign PLL_MULT = mult_r;
  assign PLL_TEST_ONLY = tst_r;
  assign CORE_RST_N = core_rst_n_r;
  assign CACHE_INV_WE = inv_we_r;
  assign CACHE_INV_IDX = line_r;
  assign IRQ_TAKE = take_r;
  assign FPU_ERROR_IRQ_OUT = fpu_irq_r;
  assign INT_OUT = int_r;

endmodule // ccr_top

// *** verif/ccr_chk_asserts.sv ***
// assertions on the ports of the core clock block
`timescale 1ns/1ps
module ccr_chk (
  // clock and reset
  input wire MCLK,
  input wire RST_N,
  // watched ports
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire [3:0] PLL_MULT,
  input wire CORE_RST_N,
  input wire CACHE_INV_WE,
  input wire [7:0] CACHE_INV_IDX,
  input wire IRQ_TAKE,
  input wire FPU_ERROR,
  input wire IO_WR,
  input wire [15:0] IO_ADDR,
  input wire FPU_ERROR_IRQ_OUT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire clr = IO_WR && (IO_ADDR == 16'h00F0 || IO_ADDR == 16'h00F1);
  sequence s_walk_end;
    CACHE_INV_WE && CACHE_INV_IDX == 8'hFF;
  endsequence
  sequence s_run;
    ##[1:3] CORE_RST_N;
  endsequence
  a_walk_done: assert property (s_walk_end |=> s_run)
    else $error("core reset not released after walk");
  a_walk_start: assert property ($rose(CACHE_INV_WE) |-> CACHE_INV_IDX == 8'h00)
    else $error("walk not started at line zero");
  a_walk_held: assert property (CACHE_INV_WE |-> !CORE_RST_N)
    else $error("core running during walk");
  a_ratio_frozen: assert property (CORE_RST_N |=> $stable(PLL_MULT))
    else $error("multiplier moved while running");
  a_mult_range: assert property (PLL_MULT >= 4'h4 && PLL_MULT <= 4'hA)
    else $error("multiplier out of range");
  a_take_pulse: assert property (IRQ_TAKE |-> CORE_RST_N ##1 !IRQ_TAKE)
    else $error("take not a single pulse");
  a_fpu_set: assert property (CORE_RST_N && FPU_ERROR |=> FPU_ERROR_IRQ_OUT)
    else $error("fpu irq not raised");
  a_fpu_clr: assert property (clr && !FPU_ERROR |=> !FPU_ERROR_IRQ_OUT)
    else $error("fpu irq not cleared");
  a_fpu_hold: assert property (FPU_ERROR_IRQ_OUT && !IO_WR |=> FPU_ERROR_IRQ_OUT)
    else $error("fpu irq dropped");
  a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
endmodule // ccr_chk
bind ccr_top ccr_chk i_ccr_chk (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PLL_MULT(PLL_MULT), .CORE_RST_N(CORE_RST_N),
  .CACHE_INV_WE(CACHE_INV_WE), .CACHE_INV_IDX(CACHE_INV_IDX), .IRQ_TAKE(IRQ_TAKE),
  .FPU_ERROR(FPU_ERROR), .IO_WR(IO_WR), .IO_ADDR(IO_ADDR),
  .FPU_ERROR_IRQ_OUT(FPU_ERROR_IRQ_OUT));

// *** verif/ccr_chip.sv ***
// interrupt controller model on the chipset side
`timescale 1ns/1ps
module ccr_chip (
  // clock, shared with the bus
  input wire MCLK,
  // request and acceptance
  input wire req,
  input wire IRQ_TAKE,
  output reg irq
);
  initial irq = 1'b0;
  always @(posedge MCLK) begin
    if (IRQ_TAKE) begin
      irq <= 1'b0;
    end else begin
      irq <= req;
    end
  end
endmodule // ccr_chip

// *** verif/ccr_top_tb_top.sv ***
// testbench for the core clock block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module ccr_top_tb_top;
  logic MCLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic PREADY, PSLVERR, er, PLL_TEST_ONLY, CORE_RST_N, CACHE_INV_WE, IRQ_TAKE;
  logic [2:0] CORE_RATIO_SELECT = 0;
  logic [3:0] PLL_MULT;
  logic [7:0] CACHE_INV_IDX;
  logic irq, req = 0, IRQ_DONE = 0, FPU_ERROR = 0, IO_WR = 0, FPU_ERROR_IRQ_OUT, INT_OUT;
  logic [15:0] IO_ADDR = 0;
  logic [3:0] tbl [8] = '{4'h4, 4'hA, 4'h9, 4'h5, 4'h4, 4'h6, 4'h7, 4'h8};
  int err_count = 0, total_checks = 0, takes = 0, invs = 0, n0;
  initial forever #12.5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (IRQ_TAKE === 1'b1) takes++;
    if (CACHE_INV_WE === 1'b1) invs++;
  end
  ccr_chip i_ccr_chip (.MCLK(MCLK), .req(req), .IRQ_TAKE(IRQ_TAKE), .irq(irq));
  ccr_top i_ccr_top (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CORE_RATIO_SELECT(CORE_RATIO_SELECT), .PLL_MULT(PLL_MULT),
    .PLL_TEST_ONLY(PLL_TEST_ONLY), .CORE_RST_N(CORE_RST_N), .CACHE_INV_WE(CACHE_INV_WE),
    .CACHE_INV_IDX(CACHE_INV_IDX), .MASKABLE_IRQ_IN(irq), .IRQ_DONE(IRQ_DONE),
    .IRQ_TAKE(IRQ_TAKE), .FPU_ERROR(FPU_ERROR), .IO_WR(IO_WR), .IO_ADDR(IO_ADDR),
    .FPU_ERROR_IRQ_OUT(FPU_ERROR_IRQ_OUT), .INT_OUT(INT_OUT));
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tmo;
    err_count++;
    report_and_stop();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1;
    do begin @(posedge MCLK); n++; if (n > 20) tmo(); end while (PREADY !== 1'b1);
    rd = PRDATA; er = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
  endtask
  task rst;
    int n;
    n = 0;
    @(posedge MCLK); RST_N <= 0;
    repeat (12) @(posedge MCLK);
    `CHK(PLL_MULT, 4'h4)
    `CHK(FPU_ERROR_IRQ_OUT, 1'b0)
    RST_N <= 1; n0 = invs;
    do begin @(negedge MCLK); n++; if (n > 400) tmo(); end while (CORE_RST_N !== 1'b1);
    `CHK(invs - n0, 256)
  endtask
  task io(input logic [15:0] a, input logic e);
    @(posedge MCLK); IO_WR <= 1; IO_ADDR <= a;
    @(posedge MCLK); IO_WR <= 0;
    @(negedge MCLK); `CHK(FPU_ERROR_IRQ_OUT, e)
  endtask
  initial begin
    for (int s = 0; s < 8; s++) begin
      CORE_RATIO_SELECT <= s[2:0];
      rst();
      `CHK(PLL_MULT, tbl[s])
      `CHK(PLL_TEST_ONLY, s == 0)
      apb(0, 12'h014, 0);
      `CHK(rd[10:0], {s[2:0], 1'b0, s == 0, 2'h2, tbl[s]})
      CORE_RATIO_SELECT <= ~s[2:0];
      repeat (6) @(posedge MCLK);
      `CHK(PLL_MULT, tbl[s])
    end
    apb(0, 12'h010, 0); `CHK(rd[7:0], 8'h24)
    apb(1, 12'h010, 1); apb(0, 12'h010, 0); `CHK(rd[7:0], 8'h24)
    apb(0, 12'h100, 0); `CHK({er, rd}, {1'b1, 32'h0000_0000})
    $display("test ratio done");
    apb(1, 12'h004, 32'h0000_0002); apb(1, 12'h00C, 0);
    @(posedge MCLK); req <= 1; n0 = takes;
    repeat (10) @(posedge MCLK);
    `CHK(takes - n0, 0)
    apb(1, 12'h00C, 1);
    repeat (10) @(posedge MCLK);
    `CHK(takes - n0, 1)
    `CHK(INT_OUT, 1'b1)
    @(posedge MCLK); req <= 0;
    repeat (5) @(posedge MCLK);
    IRQ_DONE <= 1;
    @(posedge MCLK); IRQ_DONE <= 0;
    repeat (5) @(posedge MCLK);
    `CHK(takes - n0, 1)
    apb(1, 12'h008, 32'h0000_000F); apb(0, 12'h000, 0);
    `CHK(rd[1], 1'b0)
    @(negedge MCLK); `CHK(INT_OUT, 1'b0)
    $display("test irq done");
    for (int k = 0; k < 2; k++) begin
      @(posedge MCLK); FPU_ERROR <= 1;
      @(posedge MCLK); FPU_ERROR <= 0;
      @(negedge MCLK); `CHK(FPU_ERROR_IRQ_OUT, 1'b1)
      io(16'h00F2, 1'b1);
      io(16'h00F0 + k, 1'b0);
    end
    apb(0, 12'h000, 0); `CHK(rd[3:0], 4'h9)
    @(posedge MCLK); FPU_ERROR <= 1;
    @(posedge MCLK); FPU_ERROR <= 0;
    rst();
    $display("test fpu done");
    report_and_stop();
  end
endmodule // ccr_top_tb_top
